// ---- design/dsc_device.sv ----
/*
 Device end: interprets head_command_a and the security command group,
 checks passwords from one-sector data-out payloads and reports results.
 Assumes the host keeps its own obligations and a shared synchronous reset.
*/
// Function
// RL1: CYLINDER_HEAD_SECTOR_ADDRESSING head_command_a leaves cylinders, head zero, sector 1
// RL2: LINEAR_BLOCK_ADDRESSING head_command_a leaves all address fields zero
// RL3: Seek failure sets error and track-zero flag
// RL4: Host recalibrates only while drive ready
// RL5: Disable-password takes one data-out sector
// RL6: Word0 bit0 selects user/master; words 1-16 password
// RL7: Matching password turns lock function off
// RL8: Disable keeps master password stored
// RL9: Disable, arm, erase abort if unsupported/locked/frozen
// RL10: Host disables password only when unlocked
// RL11: Host sends erase-arm directly before erase
// RL12: Erase takes a sector, aborts on mismatch
// RL13: Erase aborts unless previous command armed it
// RL14: Successful erase wipes all user data
// RL15: Erase turns lock off, master kept
// RL16: Freeze-lock enters frozen state
// RL17: Freeze aborts if unsupported or locked
// RL18: Frozen rejects lock-changing commands
// RL19: Frozen clears only at power-on reset
// RL20: Freeze while frozen completes, stays frozen
// RL21: Non-data completion clears busy, raises interrupt
// RL22: Abort sets error and aborted flags, interrupts
// RL23: Unknown security-group codes are aborted
`timescale 1ns/1ps
module dsc_device
	import dsc_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	dsc_link_if.device       link,
	input  wire logic        sec_supported_in,
	input  wire logic        sec_locked_in,
	input  wire logic        sec_enabled_in,
	input  wire logic [255:0] user_pw_in,
	input  wire logic [255:0] master_pw_in,
	input  wire logic        seek_fail_in,
	output logic             frozen_out,
	output logic             lock_clear_out,
	output logic             erase_busy_out,
	output logic             erase_done_out
);
	import dsc_pkg::*;

	typedef enum logic [2:0] {
		DSC_IDLE, DSC_SEEK, DSC_DATA, DSC_CHECK, DSC_ERASE
	} dsc_state_type;

	dsc_state_type  state_reg;
	logic [7:0]     cmd_reg;
	logic [7:0]     status_reg;
	logic [7:0]     error_reg;
	logic [7:0]     sect_reg;
	logic [7:0]     cyl_lo_reg;
	logic [7:0]     cyl_hi_reg;
	logic [3:0]     head_reg;
	logic           intrq_reg;
	logic           lba_reg;
	logic           frozen_reg;
	logic           armed_reg;
	logic           id_master_reg;
	logic [8:0]     word_cnt_reg;
	logic [255:0]   pw_reg;
	logic [15:0]    cnt_reg;
	logic           lock_clear_reg;
	logic           erase_done_reg;
	logic           done_ok;
	logic           done_abort;
	logic           pw_match;
	logic           grp_code;
	logic [7:0]     c;

	assign link.status   = status_reg;
	assign link.error    = error_reg;
	assign link.sect_num = sect_reg;
	assign link.cyl_lo   = cyl_lo_reg;
	assign link.cyl_hi   = cyl_hi_reg;
	assign link.head     = head_reg;
	assign link.intrq    = intrq_reg;
	assign frozen_out     = frozen_reg;
	assign lock_clear_out = lock_clear_reg;
	assign erase_busy_out = (state_reg == DSC_ERASE);
	assign erase_done_out = erase_done_reg;

	assign c        = link.cmd_code;
	assign grp_code = (c[7:4] == DSC_GRP_HI) ||
		((c >= DSC_GRP_LEGACY_LO) && (c <= DSC_GRP_LEGACY_HI));
	// ----------------------------------------------------------------
	// Password comparison
	// ----------------------------------------------------------------
	assign pw_match = id_master_reg ? (pw_reg == master_pw_in)
		: (sec_enabled_in && (pw_reg == user_pw_in)); // RL6

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		done_ok    <= 1'b0;
		done_abort <= 1'b0;
		if (rst_in) begin
			state_reg <= DSC_IDLE;
			cmd_reg   <= 8'h00;
			lba_reg   <= 1'b0;
			cnt_reg   <= 16'h0000;
			done_ok   <= 1'b0;
		end else begin
			case (state_reg)
				DSC_IDLE: begin
					if (link.cmd_wr) begin
						cmd_reg <= c;
						lba_reg <= link.lba_mode;
						cnt_reg <= 16'h0000;
						if (c == DSC_CMD_RECAL) begin
							state_reg <= DSC_SEEK;
						end else if (c == DSC_CMD_FREEZE) begin
							if (!sec_supported_in || sec_locked_in) begin
								done_abort <= 1'b1; // RL17
							end else begin
								done_ok <= 1'b1; // RL20
							end
						end else if (c == DSC_CMD_ERASE_ARM) begin
							if (!sec_supported_in || sec_locked_in || frozen_reg) begin
								done_abort <= 1'b1; // RL9
							end else begin
								done_ok <= 1'b1;
							end
						end else if (c == DSC_CMD_DISABLE || c == DSC_CMD_ERASE) begin
							if (!sec_supported_in || sec_locked_in || frozen_reg) begin
								done_abort <= 1'b1; // RL9 RL18
							end else if (c == DSC_CMD_ERASE && !armed_reg) begin
								done_abort <= 1'b1; // RL13
							end else begin
								state_reg <= DSC_DATA; // RL5 RL12
							end
						end else if (grp_code) begin
							done_abort <= 1'b1; // RL18 RL23
						end else begin
							done_abort <= 1'b1;
						end
					end
				end
				DSC_SEEK: begin
					cnt_reg <= cnt_reg + 16'h0001;
					if (cnt_reg == 16'(DSC_RECAL_CYC - 1)) begin
						state_reg <= DSC_IDLE;
						if (seek_fail_in) begin
							done_abort <= 1'b1; // RL3
						end else begin
							done_ok <= 1'b1;
						end
					end
				end
				DSC_DATA: begin
					if (link.data_wr && word_cnt_reg == DSC_SECT_LAST) begin
						state_reg <= DSC_CHECK;
					end
				end
				DSC_CHECK: begin
					if (!pw_match) begin
						state_reg  <= DSC_IDLE;
						done_abort <= 1'b1; // RL12
					end else if (cmd_reg == DSC_CMD_ERASE) begin
						state_reg <= DSC_ERASE;
					end else begin
						state_reg <= DSC_IDLE;
						done_ok   <= 1'b1; // RL7
					end
				end
				DSC_ERASE: begin
					cnt_reg <= cnt_reg + 16'h0001;
					if (cnt_reg == 16'(DSC_ERASE_CYC - 1)) begin
						state_reg <= DSC_IDLE;
						done_ok   <= 1'b1; // RL14
					end
				end
				default: state_reg <= DSC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Payload capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || state_reg != DSC_DATA) begin
			word_cnt_reg <= 9'h000;
			if (rst_in) begin
				pw_reg        <= '0;
				id_master_reg <= 1'b0;
			end
		end else if (link.data_wr) begin
			word_cnt_reg <= word_cnt_reg + 9'h001;
			if (word_cnt_reg == 9'h000) begin
				id_master_reg <= link.data_word[DSC_ID_BIT]; // RL6
			end else if (word_cnt_reg <= 9'(DSC_PW_LAST)) begin
				pw_reg[(int'(word_cnt_reg) - DSC_PW_FIRST) * 16 +: 16] <= link.data_word;
			end
		end
	end

	// ----------------------------------------------------------------
	// Security state: frozen, armed, lock clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			frozen_reg <= 1'b0; // RL19
		end else if (done_ok && cmd_reg == DSC_CMD_FREEZE) begin
			frozen_reg <= 1'b1; // RL16 RL20
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			armed_reg <= 1'b0;
		end else if (done_ok || done_abort) begin
			armed_reg <= done_ok && (cmd_reg == DSC_CMD_ERASE_ARM); // RL13
		end
	end

	// Master password lives outside; only the lock is released
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			lock_clear_reg <= 1'b0;
			erase_done_reg <= 1'b0;
		end else begin
			lock_clear_reg <= done_ok && (cmd_reg == DSC_CMD_DISABLE ||
				cmd_reg == DSC_CMD_ERASE); // RL7 RL8 RL15
			erase_done_reg <= done_ok && (cmd_reg == DSC_CMD_ERASE); // RL14
		end
	end

	// ----------------------------------------------------------------
	// Task file outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			status_reg <= 8'h40;
			error_reg  <= 8'h00;
			intrq_reg  <= 1'b0;
			sect_reg   <= 8'h01;
			cyl_lo_reg <= 8'h00;
			cyl_hi_reg <= 8'h00;
			head_reg   <= 4'h0;
		end else begin
			intrq_reg <= done_ok || done_abort; // RL21 RL22
			if (state_reg == DSC_IDLE && link.cmd_wr) begin
				status_reg <= 8'h00;
				status_reg[DSC_ST_BUSY] <= 1'b1;
				error_reg  <= 8'h00;
			end else if (state_reg == DSC_DATA) begin
				status_reg[DSC_ST_BUSY] <= 1'b0;
				status_reg[DSC_ST_DRQ]  <= 1'b1; // RL5
			end else if (state_reg == DSC_CHECK) begin
				status_reg[DSC_ST_DRQ]  <= 1'b0;
				status_reg[DSC_ST_BUSY] <= 1'b1;
			end
			if (done_ok || done_abort) begin
				status_reg <= 8'h00;
				status_reg[DSC_ST_READY] <= 1'b1; // RL21
				status_reg[DSC_ST_ERR]   <= done_abort; // RL22
				error_reg <= 8'h00;
				if (done_abort && cmd_reg == DSC_CMD_RECAL) begin
					error_reg[DSC_ER_TK0] <= 1'b1; // RL3
				end else if (done_abort) begin
					error_reg[DSC_ER_ABORT] <= 1'b1; // RL22
				end
				if (done_ok && cmd_reg == DSC_CMD_RECAL) begin
					cyl_lo_reg <= 8'h00;
					cyl_hi_reg <= 8'h00;
					head_reg   <= 4'h0;
					sect_reg   <= lba_reg ? 8'h00 : DSC_SECT_CHS; // RL1 RL2
				end
			end
		end
	end
endmodule : dsc_device

// ---- design/dsc_host.sv ----
/*
 Host adapter end: takes a command from the user port, issues it when idle
 (head_command_a only once the device is ready), streams a password sector and reports the outcome.
 Assumes the device end of dsc_link_if and a shared synchronous reset.
*/
`timescale 1ns/1ps
module dsc_host
	import dsc_pkg::*;
(
	input  wire logic         clk_sys_in,
	input  wire logic         rst_in,
	dsc_link_if.host          link,
	input  wire logic         req_in,
	input  wire logic [7:0]   req_code_in,
	input  wire logic         req_lba_in,
	input  wire logic         req_master_in,
	input  wire logic [255:0] req_pw_in,
	output logic              ready_out,
	output logic              done_out,
	output logic              fail_out,
	output logic [7:0]        err_out
);
	import dsc_pkg::*;

	typedef enum logic [1:0] {
		DSC_H_IDLE, DSC_H_WAIT, DSC_H_SEND
	} dsc_hstate_type;

	dsc_hstate_type state_reg;
	logic           cmd_wr_reg;
	logic [7:0]     code_reg;
	logic           lba_reg;
	logic           master_reg;
	logic [255:0]   pw_reg;
	logic           data_wr_reg;
	logic [15:0]    data_reg;
	logic [8:0]     word_reg;
	logic           done_reg;
	logic           fail_reg;
	logic [7:0]     err_reg;

	assign link.cmd_wr    = cmd_wr_reg;
	assign link.cmd_code  = code_reg;
	assign link.lba_mode  = lba_reg;
	assign link.data_wr   = data_wr_reg;
	assign link.data_word = data_reg;
	// Head_command_a waits for drive ready
	assign ready_out = (state_reg == DSC_H_IDLE) && !cmd_wr_reg &&
		(link.status[DSC_ST_READY] || req_code_in != DSC_CMD_RECAL); // RL4
	assign done_out  = done_reg;
	assign fail_out  = fail_reg;
	assign err_out   = err_reg;

	// ----------------------------------------------------------------
	// Command and payload sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		cmd_wr_reg  <= 1'b0;
		data_wr_reg <= 1'b0;
		done_reg    <= 1'b0;
		if (rst_in) begin
			state_reg  <= DSC_H_IDLE;
			code_reg   <= 8'h00;
			lba_reg    <= 1'b0;
			master_reg <= 1'b0;
			pw_reg     <= '0;
			data_reg   <= 16'h0000;
			word_reg   <= 9'h000;
			fail_reg   <= 1'b0;
			err_reg    <= 8'h00;
		end else begin
			case (state_reg)
				DSC_H_IDLE: begin
					if (req_in && ready_out) begin
						cmd_wr_reg <= 1'b1; // RL11
						code_reg   <= req_code_in;
						lba_reg    <= req_lba_in;
						master_reg <= req_master_in;
						pw_reg     <= req_pw_in;
						word_reg   <= 9'h000;
						state_reg  <= DSC_H_WAIT;
					end
				end
				DSC_H_WAIT: begin
					if (link.intrq) begin
						done_reg  <= 1'b1;
						fail_reg  <= link.status[DSC_ST_ERR];
						err_reg   <= link.error;
						state_reg <= DSC_H_IDLE;
					end else if (link.status[DSC_ST_DRQ] && !cmd_wr_reg &&
						word_reg == 9'h000) begin
						state_reg <= DSC_H_SEND; // RL5
					end
				end
				DSC_H_SEND: begin
					data_wr_reg <= 1'b1;
					word_reg    <= word_reg + 9'h001;
					if (word_reg == 9'h000) begin
						data_reg <= {15'h0000, master_reg}; // RL6
					end else if (word_reg <= 9'(DSC_PW_LAST)) begin
						data_reg <= pw_reg[(int'(word_reg) - DSC_PW_FIRST) * 16 +: 16]; // RL6
					end else begin
						data_reg <= 16'h0000;
					end
					if (word_reg == DSC_SECT_LAST) begin
						state_reg <= DSC_H_WAIT;
					end
				end
				default: state_reg <= DSC_H_IDLE;
			endcase
		end
	end
endmodule : dsc_host

// ---- design/dsc_link_if.sv ----
/*
 Interface joining the host adapter end and the device end: a command
 block with strobes, a status byte, an error byte and a 16-bit data port.
 Assumes both ends share clk_sys_in.
*/
`timescale 1ns/1ps
interface dsc_link_if;
	logic        cmd_wr;
	logic [7:0]  cmd_code;
	logic        lba_mode;
	logic [7:0]  status;
	logic [7:0]  error;
	logic [7:0]  sect_num;
	logic [7:0]  cyl_lo;
	logic [7:0]  cyl_hi;
	logic [3:0]  head;
	logic        data_wr;
	logic [15:0] data_word;
	logic        intrq;
	modport device (input cmd_wr, cmd_code, lba_mode, data_wr, data_word,
		output status, error, sect_num, cyl_lo, cyl_hi, head, intrq);
	modport host (output cmd_wr, cmd_code, lba_mode, data_wr, data_word,
		input status, error, sect_num, cyl_lo, cyl_hi, head, intrq);
endinterface : dsc_link_if

// ---- design/dsc_pkg.sv ----
/*
 Package for the drive security command logic: command codes, status and
 error bit positions, payload layout and timing counts.
 Assumes a single 250 MHz clock shared by both ends.
*/
package dsc_pkg;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] DSC_CMD_RECAL     = 8'h10;
	localparam logic [7:0] DSC_CMD_SET_PW    = 8'hF1;
	localparam logic [7:0] DSC_CMD_UNLOCK    = 8'hF2;
	localparam logic [7:0] DSC_CMD_ERASE_ARM = 8'hF3;
	localparam logic [7:0] DSC_CMD_ERASE     = 8'hF4;
	localparam logic [7:0] DSC_CMD_FREEZE    = 8'hF5;
	localparam logic [7:0] DSC_CMD_DISABLE   = 8'hF6;
	localparam logic [3:0] DSC_GRP_HI        = 4'hF;
	localparam logic [7:0] DSC_GRP_LEGACY_LO = 8'hBA;
	localparam logic [7:0] DSC_GRP_LEGACY_HI = 8'hBF;
	// ----------------------------------------------------------------
	// Status and error bit positions
	// ----------------------------------------------------------------
	localparam int DSC_ST_ERR   = 0;
	localparam int DSC_ST_DRQ   = 3;
	localparam int DSC_ST_FAULT = 5;
	localparam int DSC_ST_READY = 6;
	localparam int DSC_ST_BUSY  = 7;
	localparam int DSC_ER_TK0   = 1;
	localparam int DSC_ER_ABORT = 2;
	// ----------------------------------------------------------------
	// Payload layout, in 16-bit words
	// ----------------------------------------------------------------
	localparam int          DSC_PW_FIRST  = 1;
	localparam int          DSC_PW_LAST   = 16;
	localparam int          DSC_PW_WORDS  = 16;
	localparam logic [8:0]  DSC_SECT_LAST = 9'h0FF;
	localparam int          DSC_ID_BIT    = 0;
	localparam logic [7:0]  DSC_SECT_CHS  = 8'h01;
	// ----------------------------------------------------------------
	// Timing: head_command_a seek time and erase cycle count
	// ----------------------------------------------------------------
	localparam int DSC_CLK_MHZ       = 250;
	localparam int DSC_RECAL_TIME_NS = 400;
	localparam int DSC_RECAL_CYC     = DSC_RECAL_TIME_NS * DSC_CLK_MHZ / 1000;
	localparam int DSC_ERASE_CYC     = 64;
endpackage : dsc_pkg

// ---- tb/dsc_bench.sv ----
/*
 Testbench joining host end and device end, driving both user sides.
 Assumes the design files and dsc_link_checker are compiled first.
*/
`timescale 1ns/1ps
module dsc_bench;
	import dsc_pkg::*;
	localparam logic [255:0] PW_U =
		256'h0123456789ABCDEF_FEDCBA9876543210_0011223344556677_8899AABBCCDDEEFF;
	localparam logic [255:0] PW_M = {16{16'hBEEF}};
	localparam logic [255:0] PW_X = PW_U ^ 256'h1;
	localparam logic [7:0]   OK   = 8'h00;
	localparam logic [7:0]   ABT  = 8'h04;
	logic         clk_sys_in, rst_in, req_in, req_lba_in, req_master_in;
	logic         ready_out, done_out, fail_out, sup, lck, seek_fail;
	logic         frozen_out, lock_clear_out, erase_busy_out, erase_done_out;
	logic         saw_clear, saw_erase, saw_busy, ena;
	logic [7:0]   req_code_in, err_out;
	logic [255:0] req_pw_in;
	logic [7:0]   lst [4] = '{DSC_CMD_DISABLE, DSC_CMD_ERASE_ARM, DSC_CMD_ERASE, DSC_CMD_FREEZE};
	logic [7:0]   unk [5] = '{DSC_CMD_SET_PW, DSC_CMD_UNLOCK, 8'hF7, 8'hBA, 8'hBF};
	int           n_errors, checks;
	dsc_link_if link();
	dsc_host u_dsc_host(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link.host),
		.req_in(req_in), .req_code_in(req_code_in), .req_lba_in(req_lba_in),
		.req_master_in(req_master_in), .req_pw_in(req_pw_in), .ready_out(ready_out),
		.done_out(done_out), .fail_out(fail_out), .err_out(err_out));
	dsc_device u_dsc_device(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link.device),
		.sec_supported_in(sup), .sec_locked_in(lck), .sec_enabled_in(ena),
		.user_pw_in(PW_U), .master_pw_in(PW_M), .seek_fail_in(seek_fail),
		.frozen_out(frozen_out), .lock_clear_out(lock_clear_out),
		.erase_busy_out(erase_busy_out), .erase_done_out(erase_done_out));
	dsc_link_checker u_dsc_link_checker(.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cmd_wr(link.cmd_wr), .cmd_code(link.cmd_code), .lba_mode(link.lba_mode),
		.status(link.status), .error(link.error), .sect_num(link.sect_num),
		.cyl_lo(link.cyl_lo), .cyl_hi(link.cyl_hi), .head(link.head), .intrq(link.intrq));
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask : chk
	task automatic run(input logic [7:0] code, input logic linear_block_addressing, input logic mst,
		input logic [255:0] pw, input logic [7:0] exp_err);
		int n;
		n = 0;
		while (ready_out !== 1'b1 && n < 3000) begin
			@(posedge clk_sys_in);
			n++;
		end
		req_code_in   <= code;
		req_lba_in    <= linear_block_addressing;
		req_master_in <= mst;
		req_pw_in     <= pw;
		req_in        <= 1'b1;
		@(posedge clk_sys_in);
		req_in    <= 1'b0;
		saw_clear = 1'b0;
		saw_erase = 1'b0;
		saw_busy = 1'b0;
		while (done_out !== 1'b1 && n < 3000) begin
			@(posedge clk_sys_in);
			n++;
			if (lock_clear_out === 1'b1) saw_clear = 1'b1;
			if (erase_busy_out === 1'b1) saw_busy = 1'b1;
			if (erase_done_out === 1'b1) saw_erase = 1'b1;
		end
		if (n >= 3000) begin
			n_errors++;
			summarize();
		end
		chk({15'h0000, fail_out}, {15'h0000, exp_err != 8'h00});
		chk({8'h00, err_out}, {8'h00, exp_err});
	endtask : run
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rst_in = 1'b1;
		req_in = 1'b0;
		req_code_in = 8'h00;
		req_lba_in = 1'b0;
		req_master_in = 1'b0;
		req_pw_in = '0;
		sup = 1'b1;
		ena = 1'b1;
		lck = 1'b0;
		seek_fail = 1'b0;
		n_errors = 0;
		checks = 0;
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		run(DSC_CMD_RECAL, 1'b1, 1'b0, PW_U, OK);
		chk({8'h00, link.sect_num}, 16'h0000);
		run(DSC_CMD_RECAL, 1'b0, 1'b0, PW_U, OK);
		chk({8'h00, link.sect_num}, 16'h0001);
		chk({link.cyl_hi, link.cyl_lo}, 16'h0000);
		chk({12'h000, link.head}, 16'h0000);
		seek_fail <= 1'b1;
		run(DSC_CMD_RECAL, 1'b0, 1'b0, PW_U, 8'h02);
		seek_fail <= 1'b0;
		run(DSC_CMD_DISABLE, 1'b0, 1'b0, PW_U, OK);
		chk({15'h0000, saw_clear}, 16'h0001);
		run(DSC_CMD_DISABLE, 1'b0, 1'b1, PW_M, OK);
		run(DSC_CMD_DISABLE, 1'b0, 1'b0, PW_M, ABT);
		run(DSC_CMD_DISABLE, 1'b0, 1'b0, PW_X, ABT);
		chk({15'h0000, saw_clear}, 16'h0000);
		ena <= 1'b0;
		run(DSC_CMD_DISABLE, 1'b0, 1'b0, PW_U, ABT);
		ena <= 1'b1;
		run(DSC_CMD_ERASE, 1'b0, 1'b0, PW_U, ABT);
		chk({13'h0000, saw_busy, saw_erase, saw_clear}, 16'h0000);
		run(DSC_CMD_ERASE_ARM, 1'b0, 1'b0, PW_U, OK);
		run(DSC_CMD_ERASE, 1'b0, 1'b0, PW_U, OK);
		chk({13'h0000, saw_busy, saw_erase, saw_clear}, 16'h0007);
		run(DSC_CMD_ERASE_ARM, 1'b0, 1'b0, PW_U, OK);
		run(DSC_CMD_RECAL, 1'b0, 1'b0, PW_U, OK);
		run(DSC_CMD_ERASE, 1'b0, 1'b0, PW_U, ABT);
		run(DSC_CMD_ERASE_ARM, 1'b0, 1'b0, PW_U, OK);
		run(DSC_CMD_ERASE, 1'b0, 1'b1, PW_X, ABT);
		for (int i = 0; i < 5; i++) run(unk[i], 1'b0, 1'b0, PW_U, ABT);
		lck <= 1'b1;
		for (int i = 0; i < 4; i++) run(lst[i], 1'b0, 1'b0, PW_U, ABT);
		lck <= 1'b0;
		sup <= 1'b0;
		for (int i = 0; i < 4; i++) run(lst[i], 1'b0, 1'b0, PW_U, ABT);
		sup <= 1'b1;
		run(DSC_CMD_FREEZE, 1'b0, 1'b0, PW_U, OK);
		chk({15'h0000, frozen_out}, 16'h0001);
		run(DSC_CMD_FREEZE, 1'b0, 1'b0, PW_U, OK);
		chk({15'h0000, frozen_out}, 16'h0001);
		for (int i = 0; i < 3; i++) run(lst[i], 1'b0, 1'b0, PW_U, ABT);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		chk({15'h0000, frozen_out}, 16'h0000);
		run(DSC_CMD_ERASE_ARM, 1'b0, 1'b0, PW_U, OK);
		summarize();
	end
endmodule : dsc_bench

// ---- tb/dsc_link_checker.sv ----
/*
 Checker for the link between host end and device end: timing of answers,
 status and error flags, head_command_a results and erase arming.
 Assumes plain connection to the dsc_link_if signals and one clock domain.
*/
`timescale 1ns/1ps
module dsc_link_checker
	import dsc_pkg::*;
(
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	input wire logic       cmd_wr,
	input wire logic [7:0] cmd_code,
	input wire logic       lba_mode,
	input wire logic [7:0] status,
	input wire logic [7:0] error,
	input wire logic [7:0] sect_num,
	input wire logic [7:0] cyl_lo,
	input wire logic [7:0] cyl_hi,
	input wire logic [3:0] head,
	input wire logic       intrq
);
	logic [7:0] last_code_reg;
	logic       last_lba_reg;
	logic       armed_reg;
	logic       go;
	// ----------------------------------------------------------------
	// Command tracking
	// ----------------------------------------------------------------
	assign go = cmd_wr && !status[DSC_ST_BUSY] && !status[DSC_ST_DRQ];
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			last_code_reg <= 8'h00;
			last_lba_reg  <= 1'b0;
		end else if (go) begin
			last_code_reg <= cmd_code;
			last_lba_reg  <= lba_mode;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			armed_reg <= 1'b0;
		end else if (intrq) begin
			armed_reg <= (last_code_reg == DSC_CMD_ERASE_ARM) && !status[DSC_ST_ERR];
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	sequence recal_go;
		go && cmd_code == DSC_CMD_RECAL;
	endsequence
	sequence recal_end;
		intrq && last_code_reg == DSC_CMD_RECAL;
	endsequence
	chk_busy_on_take: assert property (go |=> status[DSC_ST_BUSY])
		else $error("busy not raised after command");
	chk_nondata_done: assert property (go && (cmd_code == DSC_CMD_FREEZE ||
		cmd_code == DSC_CMD_ERASE_ARM) |-> ##2 (intrq && !status[DSC_ST_BUSY]))
		else $error("non-data command not completed in two cycles");
	chk_intrq_pulse: assert property (intrq |=> !intrq)
		else $error("interrupt longer than one cycle");
	chk_abort_flags: assert property (intrq && error[DSC_ER_ABORT] |->
		status[DSC_ST_ERR] && !status[DSC_ST_BUSY])
		else $error("abort without error status");
	chk_recal_chs: assert property (recal_end ##0 (!status[DSC_ST_ERR] && !last_lba_reg) |->
		sect_num == DSC_SECT_CHS && cyl_lo == 8'h00 && cyl_hi == 8'h00 && head == 4'h0)
		else $error("chs head_command_a address wrong");
	chk_recal_lba: assert property (recal_end ##0 (!status[DSC_ST_ERR] && last_lba_reg) |->
		sect_num == 8'h00 && cyl_lo == 8'h00 && cyl_hi == 8'h00 && head == 4'h0)
		else $error("lba head_command_a address wrong");
	chk_recal_fail: assert property (recal_end ##0 status[DSC_ST_ERR] |-> error[DSC_ER_TK0])
		else $error("failed head_command_a lacks track zero flag");
	chk_recal_time: assert property (recal_go |-> ##[100:104] intrq)
		else $error("head_command_a completion out of window");
	chk_recal_ready: assert property (cmd_wr && cmd_code == DSC_CMD_RECAL |->
		status[DSC_ST_READY])
		else $error("head_command_a issued without ready");
	chk_erase_unarmed: assert property (intrq && last_code_reg == DSC_CMD_ERASE &&
		!armed_reg |-> error[DSC_ER_ABORT])
		else $error("unarmed erase not aborted");
	chk_drq_request: assert property (go && cmd_code == DSC_CMD_DISABLE |->
		##2 (status[DSC_ST_DRQ] || intrq))
		else $error("disable did not request data");
endmodule : dsc_link_checker
